// ---- mode_ctrl_pkg.sv ----
package mode_ctrl_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_ADDR = 8'h00;
    localparam logic [7:0] OPMODE_ADDR = 8'h01;
    localparam logic [7:0] RTP_ADDR = 8'h02;
    localparam logic [7:0] FIRE_ADDR = 8'h0c;
    localparam logic [7:0] FORMAT_ADDR = 8'h1d;
    localparam logic [7:0] NREG = 8'h20;
    // ------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------
    localparam int SOFT_RESET_BIT = 7;
    localparam int STANDBY_BIT = 6;
    localparam int MODE_LSB = 0;
    localparam int OUTCOME_BIT = 3;
    localparam int FIRE_BIT = 0;
    localparam int FORMAT_BIT = 3;
    localparam int PWM_ANALOG_BIT = 1;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] OPMODE_RST = 8'h40;
    localparam logic [7:0] ZERO_RST = 8'h00;
    localparam logic [2:0] SOFT_RESET_CYCLES = 3'h4;
    typedef enum logic [2:0] {
        MODE_INTERNAL = 3'b000,
        MODE_EDGE = 3'b001,
        MODE_LEVEL = 3'b010,
        MODE_PWM_ANALOG = 3'b011,
        MODE_RESERVED = 3'b100,
        MODE_REALTIME = 3'b101,
        MODE_DIAG = 3'b110,
        MODE_CALIB = 3'b111
    } op_mode_t;
endpackage

// ---- reg_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module reg_mem #(
    parameter int DEPTH = 32,
    parameter int AW = 5
) (
    input wire logic clk_i, // Clock
    input wire logic ce_i, // Clock enable
    input wire logic clr_i, // Synchronous clear to zero
    input wire logic we_i, // Write strobe
    input wire logic [AW-1:0] waddr_i, // Write address
    input wire logic [7:0] wdata_i, // Write data
    input wire logic [AW-1:0] raddr_i, // Read address
    output logic [7:0] rdata_o // Registered read data
);
    logic [7:0] mem_ff [DEPTH];
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_word
            always_ff @(posedge clk_i) begin
                if (ce_i) begin
                    if (clr_i) begin
                        mem_ff[g] <= 8'h00;
                    end else if (we_i && waddr_i == AW'(g)) begin
                        mem_ff[g] <= wdata_i;
                    end
                end
            end
        end
    endgenerate
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            rdata_o <= mem_ff[raddr_i];
        end
    end
endmodule // reg_mem
`default_nettype wire

// ---- haptic_mode_trigger_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module haptic_mode_trigger_control
    import mode_ctrl_pkg::*;
(
    input wire logic mclk_i, // 40 MHz clock
    input wire logic arst_n_i, // Async reset, active low
    input wire logic ce_i, // Clock enable
    input wire logic reg_wr_i, // Register write strobe
    input wire logic reg_rd_i, // Register read strobe
    input wire logic [7:0] reg_addr_i, // Register address
    input wire logic [7:0] reg_wdata_i, // Register write data
    input wire logic trigger_input_pin_i, // Trigger/input pin
    input wire logic routine_done_i, // Diagnostic/calibration finished
    input wire logic routine_fail_i, // Routine result with done
    input wire logic playback_done_i, // Waveform playback ended
    output logic [7:0] reg_rdata_o, // Read data, two cycles after read
    output logic [7:0] opmode_o, // Operating mode register
    output logic fire_o, // Fire bit
    output logic standby_o, // Software standby
    output logic playback_start_o, // Start pulse for playback/routine
    output logic cancel_o, // Cancel pulse for active waveform
    output logic drive_pin_o, // Drive actuator from pin input
    output logic pin_is_analog_o, // Pin interpreted as analog
    output logic drive_realtime_o, // Drive actuator from playback value
    output logic [7:0] realtime_playback_value_o, // Playback value
    output logic value_signed_o, // Playback value is signed
    output logic check_outcome_flag_o // Outcome of last routine
);
    import mode_ctrl_pkg::*;
    // ------------------------------------------------------------
    // Reset release and pin sync
    // ------------------------------------------------------------
    logic rst_s1_ff, rst_s2_ff;
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    wire rst_n = rst_s2_ff;
    logic pin_s1_ff, pin_s2_ff, pin_d_ff;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_ff <= 1'b0;
            pin_s2_ff <= 1'b0;
            pin_d_ff <= 1'b0;
        end else if (ce_i) begin
            pin_s1_ff <= trigger_input_pin_i;
            pin_s2_ff <= pin_s1_ff;
            pin_d_ff <= pin_s2_ff;
        end
    end
    wire pin_rise = pin_s2_ff & ~pin_d_ff;
    wire pin_fall = ~pin_s2_ff & pin_d_ff;
    // ------------------------------------------------------------
    // Soft reset sequencer
    // ------------------------------------------------------------
    logic [7:0] opmode_ff, rtp_ff, format_ff;
    logic fire_ff, outcome_ff;
    logic [2:0] srst_cnt_ff;
    wire soft_busy = (srst_cnt_ff != 3'h0);
    wire wr_opmode = reg_wr_i && !soft_busy && reg_addr_i == OPMODE_ADDR;
    wire wr_rtp = reg_wr_i && !soft_busy && reg_addr_i == RTP_ADDR;
    wire wr_fire = reg_wr_i && !soft_busy && reg_addr_i == FIRE_ADDR;
    wire wr_format = reg_wr_i && !soft_busy && reg_addr_i == FORMAT_ADDR;
    wire wr_other = reg_wr_i && !soft_busy && reg_addr_i < NREG;
    wire soft_req = wr_opmode && reg_wdata_i[SOFT_RESET_BIT];
    wire soft_clr = soft_busy && srst_cnt_ff == 3'h1;
    wire [2:0] nxt_srst_cnt = soft_req ? SOFT_RESET_CYCLES :
                              soft_busy ? srst_cnt_ff - 3'h1 : 3'h0;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            srst_cnt_ff <= 3'h0;
        end else if (ce_i) begin
            srst_cnt_ff <= nxt_srst_cnt;
        end
    end
    // ------------------------------------------------------------
    // Mode register and data registers
    // ------------------------------------------------------------
    wire [7:0] opmode_mask = 8'hc7;
    wire [7:0] nxt_opmode = soft_req ? (OPMODE_RST | 8'h80) :
                            soft_clr ? OPMODE_RST :
                            wr_opmode ? (reg_wdata_i & opmode_mask) : opmode_ff;
    wire [2:0] mode = opmode_ff[2:0];
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            opmode_ff <= OPMODE_RST;
            rtp_ff <= ZERO_RST;
            format_ff <= ZERO_RST;
        end else if (ce_i) begin
            opmode_ff <= nxt_opmode;
            rtp_ff <= soft_clr ? ZERO_RST : wr_rtp ? reg_wdata_i : rtp_ff;
            format_ff <= soft_clr ? ZERO_RST : wr_format ? reg_wdata_i : format_ff;
        end
    end
    // ------------------------------------------------------------
    // Fire bit and trigger modes
    // ------------------------------------------------------------
    wire fire_wr1 = wr_fire && reg_wdata_i[FIRE_BIT];
    wire fire_wr0 = wr_fire && !reg_wdata_i[FIRE_BIT];
    wire is_edge = mode == MODE_EDGE;
    wire is_level = mode == MODE_LEVEL;
    wire is_routine = mode == MODE_DIAG || mode == MODE_CALIB;
    wire edge_set = is_edge && pin_rise && !fire_ff;
    wire edge_cancel = is_edge && pin_rise && fire_ff;
    wire level_set = is_level && pin_rise && !fire_ff;
    wire level_cancel = is_level && pin_fall && fire_ff;
    wire do_start = !soft_busy && ((fire_wr1 && !fire_ff && mode != MODE_RESERVED) ||
                                   edge_set || level_set);
    wire do_cancel = soft_req || edge_cancel || level_cancel ||
                     (fire_wr0 && fire_ff);
    wire self_clear = fire_ff && ((is_routine && routine_done_i) ||
                                  (!is_routine && playback_done_i));
    wire nxt_fire = do_cancel ? 1'b0 :
                    do_start ? 1'b1 :
                    self_clear ? 1'b0 : fire_ff;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            fire_ff <= 1'b0;
        end else if (ce_i) begin
            fire_ff <= nxt_fire;
        end
    end
    // ------------------------------------------------------------
    // Check outcome flag: set wins over clear-on-read
    // ------------------------------------------------------------
    wire outcome_ev = fire_ff && is_routine && routine_done_i;
    wire rd_status = reg_rd_i && reg_addr_i == STATUS_ADDR;
    wire nxt_outcome = soft_clr ? 1'b0 :
                       outcome_ev ? routine_fail_i :
                       rd_status ? 1'b0 : outcome_ff;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            outcome_ff <= 1'b0;
        end else if (ce_i) begin
            outcome_ff <= nxt_outcome;
        end
    end
    // ------------------------------------------------------------
    // Generic register storage and read path
    // ------------------------------------------------------------
    logic [7:0] mem_rdata;
    logic rd_pend_ff;
    reg_mem #(.DEPTH(32), .AW(5)) u_mem (
        .clk_i(mclk_i),
        .ce_i(ce_i),
        .clr_i(soft_clr || !rst_n),
        .we_i(wr_other),
        .waddr_i(reg_addr_i[4:0]),
        .wdata_i(reg_wdata_i),
        .raddr_i(reg_addr_i[4:0]),
        .rdata_o(mem_rdata)
    );
    // Storage words answer from the memory register one cycle after the strobe
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend_ff <= 1'b0;
        end else if (ce_i) begin
            rd_pend_ff <= reg_rd_i;
        end
    end
    wire [7:0] status_word = {4'h0, outcome_ff, 3'h0};
    wire [7:0] fire_word = {7'h00, fire_ff};
    wire [7:0] rd_mux = (reg_addr_i == STATUS_ADDR) ? status_word :
                        (reg_addr_i == OPMODE_ADDR) ? opmode_ff :
                        (reg_addr_i == RTP_ADDR) ? rtp_ff :
                        (reg_addr_i == FIRE_ADDR) ? fire_word :
                        (reg_addr_i == FORMAT_ADDR) ? format_ff : 8'h00;
    wire use_mem = reg_addr_i < NREG && reg_addr_i != STATUS_ADDR &&
                   reg_addr_i != OPMODE_ADDR && reg_addr_i != RTP_ADDR &&
                   reg_addr_i != FIRE_ADDR && reg_addr_i != FORMAT_ADDR;
    logic use_mem_ff;
    logic [7:0] rd_hold_ff;
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            use_mem_ff <= 1'b0;
            rd_hold_ff <= 8'h00;
        end else if (ce_i) begin
            use_mem_ff <= use_mem;
            rd_hold_ff <= rd_mux;
        end
    end
    // ------------------------------------------------------------
    // Drive selection and outputs
    // ------------------------------------------------------------
    wire running = !opmode_ff[STANDBY_BIT] && !soft_busy;
    wire nxt_drive_pin = running && mode == MODE_PWM_ANALOG;
    wire nxt_analog = format_ff[PWM_ANALOG_BIT];
    wire nxt_drive_rt = running && mode == MODE_REALTIME;
    wire nxt_signed = !format_ff[FORMAT_BIT];
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= 8'h00;
            opmode_o <= OPMODE_RST;
            fire_o <= 1'b0;
            standby_o <= 1'b1;
            playback_start_o <= 1'b0;
            cancel_o <= 1'b0;
            drive_pin_o <= 1'b0;
            pin_is_analog_o <= 1'b0;
            drive_realtime_o <= 1'b0;
            realtime_playback_value_o <= 8'h00;
            value_signed_o <= 1'b1;
            check_outcome_flag_o <= 1'b0;
        end else if (ce_i) begin
            reg_rdata_o <= rd_pend_ff ? (use_mem_ff ? mem_rdata : rd_hold_ff) : reg_rdata_o;
            opmode_o <= nxt_opmode;
            fire_o <= nxt_fire;
            standby_o <= nxt_opmode[STANDBY_BIT];
            playback_start_o <= do_start && !do_cancel;
            cancel_o <= do_cancel;
            drive_pin_o <= nxt_drive_pin;
            pin_is_analog_o <= nxt_analog;
            drive_realtime_o <= nxt_drive_rt;
            realtime_playback_value_o <= rtp_ff;
            value_signed_o <= nxt_signed;
            check_outcome_flag_o <= nxt_outcome;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_soft_self_clear: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && soft_req)
        |-> ##[1:8] !opmode_ff[SOFT_RESET_BIT])
        else $error("soft reset bit did not self clear");
    a_soft_restore: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && soft_clr)
        |=> (opmode_ff == OPMODE_RST && rtp_ff == 8'h00))
        else $error("soft reset did not restore defaults");
    a_soft_cancel: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && soft_req)
        |=> (cancel_o && !fire_ff))
        else $error("soft reset did not abort playback");
    a_edge_set: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && edge_set && !soft_busy && !do_cancel)
        |=> fire_ff)
        else $error("edge did not set fire");
    a_edge_cancel: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && is_edge && pin_rise && fire_ff)
        |=> (!fire_ff && cancel_o))
        else $error("second edge did not cancel");
    a_level_fall: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && is_level && pin_fall && fire_ff)
        |=> !fire_ff)
        else $error("falling edge did not cancel");
    a_level_nochange: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && is_level && pin_fall && !fire_ff && !do_start && !soft_req)
        |=> !cancel_o)
        else $error("cancel issued with fire already clear");
    a_outcome_store: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && outcome_ev && !soft_clr)
        |=> (outcome_ff == $past(routine_fail_i)))
        else $error("routine outcome not stored");
    a_rt_drive: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && nxt_drive_rt)
        |=> drive_realtime_o)
        else $error("realtime drive not raised");
    a_drive_rt_off: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && mode != MODE_REALTIME)
        |=> !drive_realtime_o)
        else $error("realtime drive outside its mode");
    a_standby_clear: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && wr_opmode && !soft_req && !reg_wdata_i[STANDBY_BIT])
        |=> (!standby_o && !opmode_ff[STANDBY_BIT]))
        else $error("standby not left on write of zero");
    a_reserved_zero: assert property (@(posedge mclk_i) disable iff (!rst_n)
        ce_i
        |-> (opmode_ff[5:3] == 3'h0))
        else $error("reserved mode bits not zero");
    a_internal_start: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && mode == MODE_INTERNAL && fire_wr1 && !fire_ff && !soft_busy)
        |=> (fire_ff && playback_start_o))
        else $error("fire write did not start playback");
    a_reserved_nostart: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && mode == MODE_RESERVED)
        |=> !playback_start_o)
        else $error("start issued in reserved mode");
    a_level_set: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && level_set && !soft_busy && !soft_req)
        |=> fire_ff)
        else $error("fire did not follow rising level");
    a_level_noset: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && is_level && pin_rise && fire_ff)
        |=> !playback_start_o)
        else $error("start issued with fire already set");
    a_pin_single: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && pin_rise)
        |=> !pin_rise)
        else $error("one pin rise gave two events");
    a_drive_pin_on: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && running && mode == MODE_PWM_ANALOG)
        |=> drive_pin_o)
        else $error("pin drive not raised");
    a_drive_pin_off: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && mode != MODE_PWM_ANALOG)
        |=> !drive_pin_o)
        else $error("pin drive outside its mode");
    a_analog_select: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && format_ff[PWM_ANALOG_BIT])
        |=> pin_is_analog_o)
        else $error("analog select not followed");
    a_unsigned_fmt: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && format_ff[FORMAT_BIT])
        |=> !value_signed_o)
        else $error("unsigned format not followed");
    a_routine_clear: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && fire_ff && is_routine && routine_done_i)
        |=> !fire_ff)
        else $error("fire did not self clear after routine");
    a_routine_start: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && is_routine && fire_wr1 && !fire_ff && !soft_busy)
        |=> (fire_ff && playback_start_o))
        else $error("fire write did not start routine");
    a_outcome_clear: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && rd_status && !outcome_ev && !soft_clr)
        |=> !outcome_ff)
        else $error("outcome flag not cleared by read");
    a_outcome_hold: assert property (@(posedge mclk_i) disable iff (!rst_n)
        (ce_i && !rd_status && !outcome_ev && !soft_clr)
        |=> (outcome_ff == $past(outcome_ff)))
        else $error("outcome flag changed without cause");
endmodule // haptic_mode_trigger_control
`default_nettype wire

// ---- haptic_engine_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module haptic_engine_model #(
    parameter int PLAY_CYCLES = 40,
    parameter int ROUTINE_CYCLES = 12
) (
    input wire logic mclk_i, // Clock
    input wire logic arst_n_i, // Async reset, active low
    input wire logic start_i, // Start pulse from the device
    input wire logic cancel_i, // Cancel pulse from the device
    input wire logic [2:0] mode_i, // Current operating mode
    input wire logic fail_i, // Outcome to report for routines
    output logic routine_done_o, // Routine finished pulse
    output logic routine_fail_o, // Routine outcome, valid with done
    output logic playback_done_o // Waveform finished pulse
);
    // ------------------------------------------------------------
    // Engine timer
    // ------------------------------------------------------------
    int cnt_ff;
    logic routine_ff;
    logic is_routine;
    assign is_routine = mode_i[2] & mode_i[1];
    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_ff <= 0;
            routine_ff <= 1'b0;
        end else if (cancel_i) begin
            cnt_ff <= 0;
        end else if (start_i) begin
            routine_ff <= is_routine;
            cnt_ff <= is_routine ? ROUTINE_CYCLES : PLAY_CYCLES;
        end else if (cnt_ff > 0) begin
            cnt_ff <= cnt_ff - 1;
        end
    end
    assign routine_done_o = (cnt_ff == 1) && routine_ff;
    assign playback_done_o = (cnt_ff == 1) && !routine_ff;
    // Outcome line is only meaningful with done; otherwise show the inverse
    assign routine_fail_o = routine_done_o ? fail_i : ~fail_i;
endmodule // haptic_engine_model
`default_nettype wire

// ---- haptic_mode_trigger_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module haptic_mode_trigger_control_tb;
    import mode_ctrl_pkg::*;
    logic mclk_i, arst_n_i, ce_i, reg_wr_i, reg_rd_i, pin, fail_cfg;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, opmode_o, rt_value;
    logic r_done, r_fail, p_done, fire_o, standby_o, start_o, cancel_o;
    logic drive_pin_o, analog_o, drive_rt_o, signed_o, outcome_o;
    int fails = 0, n_compared = 0, n_start = 0, n_cancel = 0, cycles = 0, s0, c0;
    haptic_mode_trigger_control dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .trigger_input_pin_i(pin), .routine_done_i(r_done),
        .routine_fail_i(r_fail), .playback_done_i(p_done), .reg_rdata_o(reg_rdata_o),
        .opmode_o(opmode_o), .fire_o(fire_o), .standby_o(standby_o),
        .playback_start_o(start_o), .cancel_o(cancel_o), .drive_pin_o(drive_pin_o),
        .pin_is_analog_o(analog_o), .drive_realtime_o(drive_rt_o),
        .realtime_playback_value_o(rt_value), .value_signed_o(signed_o),
        .check_outcome_flag_o(outcome_o));
    haptic_engine_model engine (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .start_i(start_o),
        .cancel_i(cancel_o), .mode_i(opmode_o[2:0]), .fail_i(fail_cfg),
        .routine_done_o(r_done), .routine_fail_o(r_fail), .playback_done_o(p_done));
    // ------------------------------------------------------------
    // Clock, pulse counters and hang guard
    // ------------------------------------------------------------
    always #12.5 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        if (start_o === 1'b1) n_start++;
        if (cancel_o === 1'b1) n_cancel++;
        cycles++;
        if (cycles == 3000) begin
            fails++;
            tally_and_finish();
        end
    end
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge mclk_i);
        reg_wr_i = 1'b0;
        repeat (2) @(negedge mclk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk_i);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(negedge mclk_i);
        reg_rd_i = 1'b0;
        @(negedge mclk_i);
        chk(reg_rdata_o, exp);
    endtask
    task automatic set_pin(input logic v);
        @(negedge mclk_i);
        pin = v;
        repeat (7) @(negedge mclk_i);
    endtask
    task automatic bit_is(input logic b, input logic exp);
        chk({7'h00, b}, {7'h00, exp});
    endtask
    task automatic wait_fire_low;
        for (int k = 0; k < 200 && fire_o !== 1'b0; k++) @(negedge mclk_i);
        bit_is(fire_o, 1'b0);
    endtask
    task automatic routine(input logic [2:0] m, input logic f);
        fail_cfg = f;
        wr(OPMODE_ADDR, {5'h00, m});
        wr(FIRE_ADDR, 8'h01);
        bit_is(fire_o, 1'b1);
        wait_fire_low();
    endtask
    task automatic tally_and_finish;
        $display("compared %0d, wrong %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        mclk_i = 1'b0; arst_n_i = 1'b0; ce_i = 1'b1; reg_wr_i = 1'b0; reg_rd_i = 1'b0;
        reg_addr_i = 8'h00; reg_wdata_i = 8'h00; pin = 1'b0; fail_cfg = 1'b0;
        repeat (2) @(negedge mclk_i);
        arst_n_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        rd(OPMODE_ADDR, OPMODE_RST);
        bit_is(standby_o, 1'b1);
        bit_is(signed_o, 1'b1);
        wr(OPMODE_ADDR, 8'h00);
        bit_is(standby_o, 1'b0);
        wr(8'h25, 8'hff);
        rd(8'h25, 8'h00);
        s0 = n_start;
        wr(FIRE_ADDR, 8'h01);
        bit_is(fire_o, 1'b1);
        chk(8'(n_start - s0), 8'h01);
        wait_fire_low();
        wr(OPMODE_ADDR, 8'h01);
        s0 = n_start;
        c0 = n_cancel;
        set_pin(1'b1);
        bit_is(fire_o, 1'b1);
        chk(8'(n_start - s0), 8'h01);
        set_pin(1'b0);
        set_pin(1'b1);
        chk(8'(n_cancel - c0), 8'h01);
        set_pin(1'b0);
        wait_fire_low();
        wr(OPMODE_ADDR, 8'h02);
        s0 = n_start;
        c0 = n_cancel;
        set_pin(1'b1);
        bit_is(fire_o, 1'b1);
        chk(8'(n_start - s0), 8'h01);
        set_pin(1'b0);
        bit_is(fire_o, 1'b0);
        chk(8'(n_cancel - c0), 8'h01);
        wr(FIRE_ADDR, 8'h01);
        s0 = n_start;
        set_pin(1'b1);
        chk(8'(n_start - s0), 8'h00);
        set_pin(1'b0);
        wait_fire_low();
        wr(OPMODE_ADDR, 8'h03);
        bit_is(drive_pin_o, 1'b1);
        wr(FORMAT_ADDR, 8'h02);
        bit_is(analog_o, 1'b1);
        wr(FORMAT_ADDR, 8'h00);
        bit_is(analog_o, 1'b0);
        wr(OPMODE_ADDR, 8'h04);
        s0 = n_start;
        wr(FIRE_ADDR, 8'h01);
        chk(8'(n_start - s0), 8'h00);
        wr(FIRE_ADDR, 8'h00);
        wr(OPMODE_ADDR, 8'h3d);
        chk(opmode_o, 8'h05);
        bit_is(drive_rt_o, 1'b1);
        bit_is(drive_pin_o, 1'b0);
        wr(RTP_ADDR, 8'h85);
        chk(rt_value, 8'h85);
        ce_i = 1'b0;
        wr(RTP_ADDR, 8'h11);
        ce_i = 1'b1;
        chk(rt_value, 8'h85);
        rd(RTP_ADDR, 8'h85);
        wr(FORMAT_ADDR, 8'h08);
        bit_is(signed_o, 1'b0);
        routine(3'h6, 1'b1);
        wr(8'h16, 8'h3c);
        rd(8'h16, 8'h3c);
        routine(3'h7, 1'b0);
        rd(STATUS_ADDR, 8'h00);
        routine(3'h6, 1'b1);
        rd(STATUS_ADDR, 8'h08);
        rd(STATUS_ADDR, 8'h00);
        wr(OPMODE_ADDR, 8'h00);
        wr(FIRE_ADDR, 8'h01);
        c0 = n_cancel;
        wr(OPMODE_ADDR, 8'h80);
        repeat (8) @(negedge mclk_i);
        rd(OPMODE_ADDR, OPMODE_RST);
        rd(RTP_ADDR, 8'h00);
        rd(8'h16, 8'h00);
        bit_is(fire_o, 1'b0);
        bit_is(signed_o, 1'b1);
        chk(8'(n_cancel - c0), 8'h01);
        tally_and_finish();
    end
endmodule // haptic_mode_trigger_control_tb
`default_nettype wire
